/* logic/timer_pkg.sv */
/*
 * Shared constants and types for the 16-bit capture/compare timer.
 * Assumes a single pclk domain and word-aligned APB accesses.
 */
package timer_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_COUNTER  = 12'h000;
  localparam logic [11:0] OFF_CMP_A    = 12'h004;
  localparam logic [11:0] OFF_CMP_B    = 12'h008;
  localparam logic [11:0] OFF_MODE     = 12'h00c;
  localparam logic [11:0] OFF_CAPMODE  = 12'h010;
  localparam logic [11:0] OFF_PRESCALE = 12'h014;
  localparam logic [11:0] OFF_OUTCTL   = 12'h018;

  // counter_mode_control fields
  localparam int MODE_WRAP_BIT = 0;
  localparam int MODE_LO_BIT   = 2;
  // capture_mode_control fields
  localparam int CAP_A_SEL_BIT = 0;
  localparam int CAP_A_INV_BIT = 1;
  localparam int CAP_B_SEL_BIT = 2;
  // prescale_edge_select fields
  localparam int CLK_SEL_LO    = 0;
  localparam int EDGE_A_LO     = 4;
  localparam int EDGE_B_LO     = 6;
  // output_control fields
  localparam int OUT_EN_BIT    = 0;
  localparam int TOG_A_BIT     = 1;
  localparam int PULSE_BIT     = 2;
  localparam int ONESHOT_BIT   = 4;
  localparam int OS_TRIG_BIT   = 6;

  // reset values and counter maximum
  localparam logic [7:0]  REG8_RESET  = 8'h00;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // prescaler divide counts (count clock = pclk / n)
  localparam logic [7:0] DIV_4   = 8'h03;
  localparam logic [7:0] DIV_16  = 8'h0f;
  localparam logic [7:0] DIV_256 = 8'hff;

  typedef enum logic [1:0] {
    OP_STOP      = 2'b00,
    OP_CLR_EDGE  = 2'b01,
    OP_FREE      = 2'b10,
    OP_CLR_MATCH = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_evt_t;

endpackage : timer_pkg

/* logic/count_prescaler.sv */
/*
 * Count clock prescaler: produces a one-cycle tick at the selected rate.
 * Assumes pclk is the only clock; tick rate follows the 2-bit select.
 */
`timescale 1ns/1ps
`default_nettype none
module count_prescaler (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic [1:0] clk_sel,
  // count clock
  output logic            tick
);
  import timer_pkg::*;

  logic [7:0] div;
  logic [7:0] limit;

  always_comb begin
    case (clk_sel)
      2'b00:   limit = 8'h00;
      2'b01:   limit = DIV_4;
      2'b10:   limit = DIV_16;
      default: limit = DIV_256;
    endcase
  end

  // free running so a mode change never stalls the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div  <= 8'h00;
      tick <= 1'b0;
    end else if (div >= limit) begin
      div  <= 8'h00;
      tick <= 1'b1;
    end else begin
      div  <= div + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule : count_prescaler
`default_nettype wire

/* logic/capture_filter.sv */
/*
 * Noise eliminator for one capture input: samples on the count tick and
 * accepts a new level only after two equal samples, then flags the edge.
 * Assumes the pin is already synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module capture_filter (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // sampling
  input  wire logic                 tick,
  input  wire logic                 pin,
  // filtered edges, one-cycle pulses
  output timer_pkg::edge_evt_t      evt
);
  import timer_pkg::*;

  logic s1;
  logic s2;
  logic level;

  // glitches no longer than one tick period never reach level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      level <= 1'b0;
      evt   <= '0;
    end else begin
      evt <= '0;
      if (tick) begin
        s1 <= pin;
        s2 <= s1;
        if (s1 == s2 && s1 != level) begin
          level    <= s1;
          evt.rise <= s1;
          evt.fall <= ~s1;
        end
      end
    end
  end

  chk_edge_needs_two: assert property (@(posedge pclk) disable iff (!presetn)
    (evt.rise || evt.fall) |-> $past(s1) == $past(s2))
    else $error("edge accepted without two equal samples");

endmodule : capture_filter
`default_nettype wire

/* logic/timer_capture_pulse_output.sv */
/*
 * 16-bit timer with capture, square-wave, pulse and one-shot output,
 * reached over APB. Assumes inputs synchronous to pclk and APB3 masters.
 */
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_pulse_output (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // capture inputs
  input  wire logic        capture_in_a,
  input  wire logic        capture_in_b,
  // timer output and interrupt requests
  output logic             timer_out_pin,
  output logic             irq_match_a,
  output logic             irq_match_b
);
  import timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] main_counter;
  logic [15:0] cmp_cap_a;
  logic [15:0] cmp_cap_b;
  logic [7:0]  counter_mode_control;
  logic [7:0]  capture_mode_control;
  logic [7:0]  prescale_edge_select;
  logic [7:0]  output_control;
  logic        one_shot_armed;

  logic        tick;
  edge_evt_t   evt_a;
  edge_evt_t   evt_b;

  count_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_sel (prescale_edge_select[CLK_SEL_LO +: 2]),
    .tick    (tick)
  );

  capture_filter u_filter_a (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .pin     (capture_in_a),
    .evt     (evt_a)
  );

  capture_filter u_filter_b (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .pin     (capture_in_b),
    .evt     (evt_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode of control fields and events
  op_mode_t  op_mode;
  edge_sel_t edge_sel_a;
  edge_sel_t edge_sel_b;
  logic      running;
  logic      reg_a_capture_sel;
  logic      reg_a_inverse_edge_sel;
  logic      reg_b_capture_sel;
  logic      out_enable;
  logic      toggle_on_match_a;
  logic      programmable_pulse;
  logic      one_shot_mode;
  logic      valid_a;
  logic      inverse_a;
  logic      valid_b;
  logic      cap_a_evt;
  logic      cap_b_evt;
  logic      match_a;
  logic      match_b;
  logic      restart;
  logic      sw_trigger;
  logic      wr_en;
  logic      rd_en;

  assign op_mode                = op_mode_t'(counter_mode_control[MODE_LO_BIT +: 2]);
  assign running                = (op_mode != OP_STOP);
  assign edge_sel_a             = edge_sel_t'(prescale_edge_select[EDGE_A_LO +: 2]);
  assign edge_sel_b             = edge_sel_t'(prescale_edge_select[EDGE_B_LO +: 2]);
  assign reg_a_capture_sel      = capture_mode_control[CAP_A_SEL_BIT];
  assign reg_a_inverse_edge_sel = capture_mode_control[CAP_A_INV_BIT];
  assign reg_b_capture_sel      = capture_mode_control[CAP_B_SEL_BIT];
  assign out_enable             = output_control[OUT_EN_BIT];
  assign toggle_on_match_a      = output_control[TOG_A_BIT];
  assign programmable_pulse     = output_control[PULSE_BIT];
  assign one_shot_mode          = output_control[ONESHOT_BIT];

  always_comb begin
    case (edge_sel_a)
      EDGE_FALL: begin
        valid_a   = evt_a.fall;
        inverse_a = evt_a.rise;
      end
      EDGE_RISE: begin
        valid_a   = evt_a.rise;
        inverse_a = evt_a.fall;
      end
      EDGE_BOTH: begin
        valid_a   = evt_a.rise | evt_a.fall;
        inverse_a = 1'b0;
      end
      default: begin
        valid_a   = 1'b0;
        inverse_a = 1'b0;
      end
    endcase
    case (edge_sel_b)
      EDGE_FALL: valid_b = evt_b.fall;
      EDGE_RISE: valid_b = evt_b.rise;
      EDGE_BOTH: valid_b = evt_b.rise | evt_b.fall;
      default:   valid_b = 1'b0;
    endcase
  end

  // a stopped timer ignores its inputs entirely
  assign cap_b_evt = running & reg_b_capture_sel & valid_a;
  assign cap_a_evt = running & reg_a_capture_sel &
                     (reg_a_inverse_edge_sel ? inverse_a : valid_b);
  assign match_a   = running & tick & ~reg_a_capture_sel & (main_counter == cmp_cap_a);
  assign match_b   = running & tick & ~reg_b_capture_sel & (main_counter == cmp_cap_b);
  assign wr_en     = psel & penable & pready & pwrite;
  assign rd_en     = psel & penable & ~pready;
  assign sw_trigger = wr_en & (paddr == OFF_OUTCTL) & pwdata[OS_TRIG_BIT] & one_shot_mode;
  assign restart   = running & ((op_mode == OP_CLR_EDGE) & valid_a | sw_trigger);

  ////////////////////////////////////////////////////////////////////////////////
  // counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_counter <= REG16_RESET;
    end else if (!running) begin
      main_counter <= REG16_RESET;
    end else if (restart) begin
      main_counter <= REG16_RESET;
    end else if (match_a && op_mode == OP_CLR_MATCH) begin
      main_counter <= REG16_RESET;
    end else if (tick) begin
      main_counter <= main_counter + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare/capture registers; a capture beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_cap_a <= REG16_RESET;
      cmp_cap_b <= REG16_RESET;
    end else begin
      if (cap_a_evt) begin
        cmp_cap_a <= main_counter;
      end else if (wr_en && paddr == OFF_CMP_A) begin
        cmp_cap_a <= pwdata[15:0];
      end
      if (cap_b_evt) begin
        cmp_cap_b <= main_counter;
      end else if (wr_en && paddr == OFF_CMP_B) begin
        cmp_cap_b <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers; the wrap flag set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_mode_control <= REG8_RESET;
      capture_mode_control <= REG8_RESET;
      prescale_edge_select <= REG8_RESET;
      output_control       <= REG8_RESET;
    end else begin
      if (wr_en && paddr == OFF_MODE) begin
        counter_mode_control <= pwdata[7:0];
      end
      if (running && tick && !restart && main_counter == COUNT_MAX &&
          !(match_a && op_mode == OP_CLR_MATCH)) begin
        counter_mode_control[MODE_WRAP_BIT] <= 1'b1;
      end
      if (wr_en && paddr == OFF_CAPMODE) begin
        capture_mode_control <= {5'h00, pwdata[2:0]};
      end
      if (wr_en && paddr == OFF_PRESCALE) begin
        prescale_edge_select <= pwdata[7:0];
      end
      if (wr_en && paddr == OFF_OUTCTL) begin
        // trigger bit is write-only and never stored
        output_control <= pwdata[7:0] & 8'hbf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output pin and interrupt requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_pin  <= 1'b0;
      one_shot_armed <= 1'b0;
    end else if (!out_enable || !running) begin
      timer_out_pin  <= 1'b0;
      one_shot_armed <= 1'b0;
    end else if (one_shot_mode) begin
      if (restart) begin
        one_shot_armed <= 1'b1;
      end else if (one_shot_armed && match_b) begin
        timer_out_pin <= 1'b1;
      end else if (one_shot_armed && match_a) begin
        timer_out_pin  <= 1'b0;
        one_shot_armed <= 1'b0;
      end
    end else if (programmable_pulse) begin
      // high for counts 0..b, so width b+1 in a period of a+1
      if (match_a) begin
        timer_out_pin <= 1'b1;
      end else if (match_b) begin
        timer_out_pin <= 1'b0;
      end
    end else if (toggle_on_match_a && match_a) begin
      timer_out_pin <= ~timer_out_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_match_a <= 1'b0;
      irq_match_b <= 1'b0;
    end else begin
      irq_match_a <= match_a | cap_a_evt |
                     (running & reg_a_capture_sel & reg_a_inverse_edge_sel & valid_b);
      irq_match_b <= match_b | cap_b_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb: one wait state, read data and pready both from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (rd_en || (psel && penable && !pready)) begin
        case (paddr)
          OFF_COUNTER:  prdata <= {16'h0000, main_counter};
          OFF_CMP_A:    prdata <= {16'h0000, cmp_cap_a};
          OFF_CMP_B:    prdata <= {16'h0000, cmp_cap_b};
          OFF_MODE:     prdata <= {24'h000000, counter_mode_control};
          OFF_CAPMODE:  prdata <= {24'h000000, capture_mode_control};
          OFF_PRESCALE: prdata <= {24'h000000, prescale_edge_select};
          OFF_OUTCTL:   prdata <= {24'h000000, output_control};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence apb_access_s;
    psel && !penable ##1 psel && penable;
  endsequence

  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access_s |=> pready)
    else $error("apb answer not one cycle after access");

  chk_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
    !running |=> main_counter == 16'h0000)
    else $error("stopped counter not held at zero");

  chk_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
    running && tick && !restart && main_counter == COUNT_MAX && op_mode == OP_FREE
    |=> main_counter == REG16_RESET && counter_mode_control[MODE_WRAP_BIT])
    else $error("wrap did not set the flag");

  chk_capture_b: assert property (@(posedge pclk) disable iff (!presetn)
    cap_b_evt |=> cmp_cap_b == $past(main_counter) && irq_match_b)
    else $error("input a edge not captured into b");

  chk_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    running && reg_a_capture_sel && !reg_a_inverse_edge_sel && valid_b
    |=> cmp_cap_a == $past(main_counter) && irq_match_a)
    else $error("input b edge not captured into a");

  chk_inverse_irq: assert property (@(posedge pclk) disable iff (!presetn)
    running && reg_a_capture_sel && reg_a_inverse_edge_sel && valid_b && !inverse_a
    && !(wr_en && paddr == OFF_CMP_A) |=> irq_match_a && $stable(cmp_cap_a))
    else $error("inverse mode b edge mishandled");

  chk_both_no_inverse: assert property (@(posedge pclk) disable iff (!presetn)
    edge_sel_a == EDGE_BOTH |-> !inverse_a)
    else $error("inverse capture with both edges selected");

  chk_restart_clear: assert property (@(posedge pclk) disable iff (!presetn)
    running && op_mode == OP_CLR_EDGE && valid_a |=> main_counter == 16'h0000)
    else $error("restart edge did not clear counter");

  chk_square_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    out_enable && toggle_on_match_a && !programmable_pulse && !one_shot_mode && match_a
    |=> timer_out_pin != $past(timer_out_pin))
    else $error("square wave did not toggle on match");

  chk_pulse_fall: assert property (@(posedge pclk) disable iff (!presetn)
    out_enable && programmable_pulse && !one_shot_mode && match_b && !match_a
    |=> !timer_out_pin)
    else $error("pulse output not inactive after b match");

endmodule : timer_capture_pulse_output
`default_nettype wire

/* tb/pulse_source.sv */
/*
 * Partner model: pulse sources on both capture inputs and a load on the
 * timer pin that measures how long each output level lasts.
 * Assumes one pclk domain; pulses are whole pclk cycles long.
 */
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  // clock
  input  wire logic pclk,
  // pins
  input  wire logic timer_out_pin,
  output logic      capture_in_a,
  output logic      capture_in_b,
  // load measurements, pclk cycles
  output var int    high_len,
  output var int    low_len
);
  int   run;
  logic prev;
  initial begin
    capture_in_a = 1'b0;
    capture_in_b = 1'b0;
    high_len     = 0;
    low_len      = 0;
    run          = 0;
    prev         = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // levels change just after an edge; widths stay under one counter period
  task automatic pulse(input bit sel, input int dly, input int width);
    repeat (dly) @(posedge pclk);
    if (sel) capture_in_b <= 1'b1; else capture_in_a <= 1'b1;
    repeat (width) @(posedge pclk);
    if (sel) capture_in_b <= 1'b0; else capture_in_a <= 1'b0;
  endtask : pulse
  //////////////////////////////////////////////////////////////////////
  // load: length of the level that just ended
  always @(posedge pclk) begin
    if (timer_out_pin !== prev) begin
      if (prev) high_len <= run; else low_len <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    prev <= timer_out_pin;
  end
endmodule : pulse_source
`default_nettype wire

/* tb/tb_top.sv */
/*
 * Testbench: APB tasks and directed sequences for the capture timer.
 * Assumes count clock select 00 gives one tick per pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v1, v2;
  logic        cin_a, cin_b, tout, irq_a, irq_b;
  int          high_len, low_len, error_cnt, cmp_count, cyc, na, nb;

  timer_capture_pulse_output i_timer_capture_pulse_output (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_in_a(cin_a),
    .capture_in_b(cin_b), .timer_out_pin(tout), .irq_match_a(irq_a),
    .irq_match_b(irq_b));
  pulse_source i_pulse_source (
    .pclk(pclk), .timer_out_pin(tout), .capture_in_a(cin_a),
    .capture_in_b(cin_b), .high_len(high_len), .low_len(low_len));
  //////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // entered just after an edge; idle cycle first keeps one driver per step
  // no local limit: only the bench cycle ceiling ends a wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // stop first so configuration writes never hit a running counter
  task automatic cfg(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, OFF_MODE, 32'h0);
    apb(1'b1, a, d);
  endtask : cfg
  task automatic wait_irq(input bit sel, input int t);
    int n;
    n = 0;
    while (((sel ? na : nb) < t) && n < 200) begin @(posedge pclk); n++; end
    chk(32'(sel ? na : nb), 32'(t));
  endtask : wait_irq
  //////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (irq_a === 1'b1) na <= na + 1;
    if (irq_b === 1'b1) nb <= nb + 1;
    cyc <= cyc + 1;
    if (cyc == 95000) begin error_cnt++; results(); end
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; error_cnt = 0; cmp_count = 0;
    cyc = 0; na = 0; nb = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rdchk(12'(i * 4), 32'h0);
    apb(1'b1, 12'h01c, 32'h5); chk(32'(err), 32'h1);
    rdchk(12'h01c, 32'h0);
    apb(1'b1, OFF_PRESCALE, 32'hf0); rdchk(OFF_PRESCALE, 32'hf0);
    apb(1'b1, OFF_CAPMODE, 32'h05); rdchk(OFF_CAPMODE, 32'h05);
    apb(1'b0, OFF_COUNTER, 0); v1 = rd;
    rdchk(OFF_COUNTER, v1);
    apb(1'b1, OFF_MODE, 32'h08);
    apb(1'b0, OFF_COUNTER, 0); v1 = rd;
    // one apb call spans four pclk, so four ticks between the two reads
    rdchk(OFF_COUNTER, v1 + 4);
    // two inputs, both edges, overlapping pulses
    fork
      i_pulse_source.pulse(1'b0, 2, 40);
      i_pulse_source.pulse(1'b1, 10, 60);
    join_none
    wait_irq(1'b0, 1); apb(1'b0, OFF_CMP_B, 0); v1 = rd;
    wait_irq(1'b1, 1); apb(1'b0, OFF_CMP_A, 0); v2 = rd;
    wait_irq(1'b0, 2); rdchk(OFF_CMP_B, v1 + 40);
    wait_irq(1'b1, 2); rdchk(OFF_CMP_A, v2 + 60);
    i_pulse_source.pulse(1'b0, 0, 1);
    i_pulse_source.pulse(1'b1, 0, 1);
    repeat (10) @(posedge pclk);
    chk(32'(na + nb), 32'd4);
    // inverse edge capture, rising edges
    cfg(OFF_PRESCALE, 32'h50);
    apb(1'b1, OFF_CAPMODE, 32'h07); apb(1'b1, OFF_MODE, 32'h08);
    fork i_pulse_source.pulse(1'b0, 2, 25); join_none
    wait_irq(1'b0, 3); apb(1'b0, OFF_CMP_B, 0); v1 = rd;
    repeat (30) @(posedge pclk);
    rdchk(OFF_CMP_A, v1 + 25);
    i_pulse_source.pulse(1'b1, 2, 10);
    // the inverse capture already raised irq a once, the b edge makes four
    wait_irq(1'b1, 4); rdchk(OFF_CMP_A, v1 + 25);
    // both-edge select: no inverse capture
    cfg(OFF_PRESCALE, 32'h70);
    apb(1'b1, OFF_MODE, 32'h08);
    apb(1'b0, OFF_CMP_A, 0); v2 = rd;
    i_pulse_source.pulse(1'b0, 2, 15);
    repeat (10) @(posedge pclk);
    rdchk(OFF_CMP_A, v2); chk(32'(nb), 32'd5);
    // restart measurement: edges 50 ticks apart
    cfg(OFF_PRESCALE, 32'h10);
    apb(1'b1, OFF_CAPMODE, 32'h04); apb(1'b1, OFF_MODE, 32'h04);
    i_pulse_source.pulse(1'b0, 2, 10);
    i_pulse_source.pulse(1'b0, 40, 10);
    repeat (10) @(posedge pclk);
    rdchk(OFF_CMP_B, 32'd49);
    // square wave, compare a kept nonzero
    cfg(OFF_CAPMODE, 32'h00);
    apb(1'b1, OFF_CMP_A, 32'd9); apb(1'b1, OFF_OUTCTL, 32'h03);
    apb(1'b1, OFF_MODE, 32'h0c);
    repeat (60) @(posedge pclk);
    chk(32'(high_len), 32'd10); chk(32'(low_len), 32'd10);
    // programmable pulse, 0 < b < a; compare a only changed while stopped
    cfg(OFF_CMP_A, 32'd19);
    apb(1'b1, OFF_CMP_B, 32'd4); apb(1'b1, OFF_OUTCTL, 32'h05);
    apb(1'b1, OFF_MODE, 32'h0c);
    repeat (100) @(posedge pclk);
    chk(32'(high_len), 32'd5); chk(32'(low_len), 32'd15);
    // one-shot by software trigger
    cfg(OFF_CMP_A, 32'd12);
    apb(1'b1, OFF_CMP_B, 32'd5); apb(1'b1, OFF_OUTCTL, 32'h11);
    apb(1'b1, OFF_MODE, 32'h08); apb(1'b1, OFF_OUTCTL, 32'h51);
    rdchk(OFF_OUTCTL, 32'h11);
    repeat (30) @(posedge pclk);
    chk(32'(high_len), 32'd7);
    // one-shot by a rising edge on input a, high from count 3 to 12
    cfg(OFF_CMP_B, 32'd3);
    apb(1'b1, OFF_MODE, 32'h04);
    i_pulse_source.pulse(1'b0, 2, 3);
    repeat (30) @(posedge pclk);
    chk(32'(high_len), 32'd9);
    // free run through a full wrap
    cfg(OFF_OUTCTL, 32'h00);
    apb(1'b1, OFF_MODE, 32'h08);
    repeat (65600) @(posedge pclk);
    rdchk(OFF_MODE, 32'h09);
    apb(1'b1, OFF_MODE, 32'h08); rdchk(OFF_MODE, 32'h08);
    results();
  end
endmodule : tb_top
`default_nettype wire
